// *** include/ubc_trace_pkg.sv ***
// Purpose: Shared constants for the break counter, branch trace and space-id block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package ubc_trace_pkg;
    // Bus geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_COUNT     = 8'h04;
    localparam logic [7:0]  OFS_SRC_TRACE = 8'h08;
    localparam logic [7:0]  OFS_DST_TRACE = 8'h0C;
    localparam logic [7:0]  OFS_SPACE_A   = 8'h10;
    localparam logic [7:0]  OFS_SPACE_B   = 8'h14;
    // Control field positions
    localparam int          CTRL_COUNT_EN_BIT = 0;
    localparam int          CTRL_TRACE_EN_BIT = 11;
    localparam int          CTRL_MASK_B_BIT   = 20;
    localparam int          CTRL_MASK_A_BIT   = 21;
    localparam logic [31:0] CTRL_WRITE_MASK   = 32'h0030_0801;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    // Execution count field
    localparam int          COUNT_W       = 12;
    localparam logic [11:0] COUNT_RESET   = 12'h000;
    localparam logic [11:0] COUNT_ONE     = 12'h001;
    // Trace entry layout
    localparam int          TRACE_ADDR_W  = 28;
    localparam int          PTR_W         = 3;
    localparam int          VALID_BIT     = 31;
    localparam int          PTR_LSB       = 28;
    localparam logic [2:0]  PTR_ODD_STEP  = 3'h2;
    // Space identifier
    localparam int          SPACE_W       = 8;
    // Queue depth
    localparam int          TRACE_DEPTH   = 8;
endpackage

// *** design/break_count_branch_trace_asid.sv ***
// Purpose: Channel B execution-count break, eight-deep branch trace queues,
//          per-channel space-id compare, reached over APB
// Assumes: Core-side inputs are on I_CLOCK; manual reset is a synchronous level
// Notes:   Trace reads pop the oldest valid entry
//
// How it works
// - Power-on reset zeroes the execution count
// - Enabled channel B hits decrement a nonzero count
// - Break only when hit with count one
// - Count has twelve bits, upper twenty zero
// - Largest count is 4095
// - Source entry keeps last fetch address
// - Source entry keeps decode buffer pointer
// - Odd pointer means buffer is pointer plus two
// - Source valid sets on capture, clears on read
// - Manual reset clears only trace valid flags
// - Eight source entries shift on each traced branch
// - Destination entry keeps first fetch after branch
// - Destination valid sets on capture, clears on read
// - Destination bits 30 to 28 read zero
// - Eight destination entries shift with source
// - Channel A space id, eight bits, unreset
// - Channel B space id, eight bits, unreset
// - Control bit 0 enables count break
// - Control bit 21 skips channel A id
// - Control bit 20 skips channel B id
// - Control bit 11 enables branch tracing
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module break_count_branch_trace_asid #(
    parameter int DEPTH = ubc_trace_pkg::TRACE_DEPTH
) (
    // Clock and power-on reset
    input  wire logic                                 I_CLOCK,
    input  wire logic                                 I_RESET_N,
    // Manual reset from the core, active low level
    input  wire logic                                 I_MANUAL_RESET_N,
    // APB slave
    input  wire logic                                 I_PSEL,
    input  wire logic                                 I_PENABLE,
    input  wire logic                                 I_PWRITE,
    input  wire logic [ubc_trace_pkg::ADDR_W-1:0]     I_PADDR,
    input  wire logic [ubc_trace_pkg::DATA_W-1:0]     I_PWDATA,
    output logic      [ubc_trace_pkg::DATA_W-1:0]     O_PRDATA,
    output logic                                      O_PREADY,
    output logic                                      O_PSLVERR,
    // Bus-cycle match events from the core
    input  wire logic                                 I_CHAN_A_MATCH,
    input  wire logic                                 I_CHAN_B_MATCH,
    input  wire logic [ubc_trace_pkg::SPACE_W-1:0]    I_BUS_SPACE_ID,
    // Branch events from the core
    input  wire logic                                 I_BRANCH,
    input  wire logic [ubc_trace_pkg::TRACE_ADDR_W-1:0] I_SRC_FETCH_ADDR,
    input  wire logic [ubc_trace_pkg::PTR_W-1:0]      I_LAST_EXEC_BUFFER,
    input  wire logic [ubc_trace_pkg::TRACE_ADDR_W-1:0] I_DST_FETCH_ADDR,
    // Break request to the core
    output logic                                      O_USER_BREAK,
    output logic                                      O_CHAN_A_HIT,
    output logic                                      O_CHAN_B_HIT
);
    import ubc_trace_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    // Elaboration check on the queue depth
    if (DEPTH < 2 || DEPTH > 64) begin : g_bad_depth
        $error("DEPTH must lie between 2 and 64");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [31:0]             ctrl;
    logic [COUNT_W-1:0]      exec_count_break_counter;   // Up to 4095
    logic [SPACE_W-1:0]      break_space_id_a;
    logic [SPACE_W-1:0]      break_space_id_b;
    logic [TRACE_ADDR_W-1:0] source_fetch_addr [DEPTH];
    logic [PTR_W-1:0]        decode_buffer_pointer [DEPTH];
    logic [TRACE_ADDR_W-1:0] destination_fetch_addr [DEPTH];
    logic [DEPTH-1:0]        source_entry_valid;
    logic [DEPTH-1:0]        destination_entry_valid;
    logic [31:0]             prdata;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire        setup_phase = I_PSEL & ~I_PENABLE;
    wire        access_phase = I_PSEL & I_PENABLE;
    wire        hit_ctrl = (I_PADDR == OFS_CTRL);
    wire        hit_count = (I_PADDR == OFS_COUNT);
    wire        hit_src = (I_PADDR == OFS_SRC_TRACE);
    wire        hit_dst = (I_PADDR == OFS_DST_TRACE);
    wire        hit_space_a = (I_PADDR == OFS_SPACE_A);
    wire        hit_space_b = (I_PADDR == OFS_SPACE_B);
    wire        mapped = hit_ctrl | hit_count | hit_src | hit_dst | hit_space_a | hit_space_b;
    wire        wr_strobe = access_phase & I_PWRITE;
    wire        rd_take = setup_phase & ~I_PWRITE;
    wire        src_pop = rd_take & hit_src;
    wire        dst_pop = rd_take & hit_dst;

    // Zero-wait slave; unmapped addresses answer with an error
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = access_phase & ~mapped;
    assign O_PRDATA  = prdata;

    ////////////////////////////////////////////////////////////////////////////
    // Control fields
    wire count_break_enable   = ctrl[CTRL_COUNT_EN_BIT];
    wire branch_trace_enable  = ctrl[CTRL_TRACE_EN_BIT];
    wire chan_a_space_id_mask = ctrl[CTRL_MASK_A_BIT];
    wire chan_b_space_id_mask = ctrl[CTRL_MASK_B_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Channel conditions with space-id compare
    wire space_a_equal = (I_BUS_SPACE_ID == break_space_id_a);
    wire space_b_equal = (I_BUS_SPACE_ID == break_space_id_b);
    wire chan_a_cond = I_CHAN_A_MATCH & (chan_a_space_id_mask | space_a_equal);
    wire chan_b_cond = I_CHAN_B_MATCH & (chan_b_space_id_mask | space_b_equal);

    ////////////////////////////////////////////////////////////////////////////
    // Execution count break
    wire count_at_one = (exec_count_break_counter == COUNT_ONE);
    wire count_at_zero = (exec_count_break_counter == COUNT_RESET);
    wire count_step = count_break_enable & chan_b_cond & ~count_at_zero;
    wire chan_b_break = count_break_enable ? (chan_b_cond & count_at_one)
                                           : chan_b_cond;
    wire count_write = wr_strobe & hit_count;
    // Software write takes priority over a decrement in the same cycle
    wire [COUNT_W-1:0] next_count = count_write ? I_PWDATA[COUNT_W-1:0]
                                  : count_step  ? exec_count_break_counter - COUNT_ONE
                                  : exec_count_break_counter;

    assign O_CHAN_A_HIT = chan_a_cond;
    assign O_CHAN_B_HIT = chan_b_cond;
    assign O_USER_BREAK = chan_a_cond | chan_b_break;

    ////////////////////////////////////////////////////////////////////////////
    // Oldest valid entry of each queue, the one a read pops
    logic [IDX_W-1:0] src_oldest;
    logic [IDX_W-1:0] dst_oldest;
    always_comb begin
        src_oldest = IDX_W'(DEPTH - 1);
        dst_oldest = IDX_W'(DEPTH - 1);
        for (int i = 0; i < DEPTH; i++) begin
            if (source_entry_valid[i]) begin
                src_oldest = IDX_W'(i);
            end
            if (destination_entry_valid[i]) begin
                dst_oldest = IDX_W'(i);
            end
        end
    end

    // Read views of the entries
    wire [31:0] src_word = {source_entry_valid[src_oldest],
                            decode_buffer_pointer[src_oldest],
                            source_fetch_addr[src_oldest]};
    wire [31:0] dst_word = {destination_entry_valid[dst_oldest], 3'h0,
                            destination_fetch_addr[dst_oldest]};

    ////////////////////////////////////////////////////////////////////////////
    // Valid flags: a read clears, then a branch shifts and sets entry 0
    wire              capture = I_BRANCH & branch_trace_enable;
    wire [DEPTH-1:0]  src_one = {{(DEPTH-1){1'b0}}, 1'b1};
    wire [DEPTH-1:0]  src_after_read = source_entry_valid
                                       & ~(src_pop ? (src_one << src_oldest) : '0);
    wire [DEPTH-1:0]  dst_after_read = destination_entry_valid
                                       & ~(dst_pop ? (src_one << dst_oldest) : '0);
    wire [DEPTH-1:0]  next_src_valid = capture ? {src_after_read[DEPTH-2:0], 1'b1}
                                               : src_after_read;
    wire [DEPTH-1:0]  next_dst_valid = capture ? {dst_after_read[DEPTH-2:0], 1'b1}
                                               : dst_after_read;

    // Buffer number to decode pointer: odd buffers store buffer minus two
    wire [PTR_W-1:0]  next_pointer = I_LAST_EXEC_BUFFER[0]
                                   ? I_LAST_EXEC_BUFFER - PTR_ODD_STEP
                                   : I_LAST_EXEC_BUFFER;

    // Read data selection
    wire [31:0] read_mux = hit_ctrl    ? ctrl
                         : hit_count   ? {20'h0_0000, exec_count_break_counter}
                         : hit_src     ? src_word
                         : hit_dst     ? dst_word
                         : hit_space_a ? {24'h00_0000, break_space_id_a}
                         : hit_space_b ? {24'h00_0000, break_space_id_b}
                         : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Control and counter, cleared by power-on reset
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl                     <= CTRL_RESET;
            exec_count_break_counter <= COUNT_RESET;
            prdata                   <= 32'h0000_0000;
        end else begin
            if (wr_strobe && hit_ctrl) begin
                ctrl <= I_PWDATA & CTRL_WRITE_MASK;
            end
            exec_count_break_counter <= next_count;
            if (rd_take) begin
                prdata <= read_mux;
            end
        end
    end

    // Valid flags, cleared by either reset
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            source_entry_valid      <= '0;
            destination_entry_valid <= '0;
        end else if (!I_MANUAL_RESET_N) begin
            source_entry_valid      <= '0;
            destination_entry_valid <= '0;
        end else begin
            source_entry_valid      <= next_src_valid;
            destination_entry_valid <= next_dst_valid;
        end
    end

    // Space-id registers keep their contents across resets
    always_ff @(posedge I_CLOCK) begin
        if (wr_strobe && hit_space_a) begin
            break_space_id_a <= I_PWDATA[SPACE_W-1:0];
        end
        if (wr_strobe && hit_space_b) begin
            break_space_id_b <= I_PWDATA[SPACE_W-1:0];
        end
    end

    // Trace payload queues, no reset, shift on every traced branch
    always_ff @(posedge I_CLOCK) begin
        if (capture) begin
            source_fetch_addr[0]      <= I_SRC_FETCH_ADDR;
            decode_buffer_pointer[0]  <= next_pointer;
            destination_fetch_addr[0] <= I_DST_FETCH_ADDR;
            for (int i = 1; i < DEPTH; i++) begin
                source_fetch_addr[i]      <= source_fetch_addr[i-1];
                decode_buffer_pointer[i]  <= decode_buffer_pointer[i-1];
                destination_fetch_addr[i] <= destination_fetch_addr[i-1];
            end
        end
    end

endmodule

`default_nettype wire

// *** tb/break_trace_checker.sv ***
// Purpose: Port-level checks of the break outputs and register read words
// Assumes: Control word tracked from completed APB writes
// Notes:   Bound into the design top module
`timescale 1ns/10ps
`default_nettype none
module break_trace_checker
    import ubc_trace_pkg::*;
(
    // Clock and reset
    input  wire logic        I_CLOCK,
    input  wire logic        I_RESET_N,
    // APB
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [31:0] O_PRDATA,
    // Break side
    input  wire logic        I_CHAN_A_MATCH,
    input  wire logic        I_CHAN_B_MATCH,
    input  wire logic        O_USER_BREAK,
    input  wire logic        O_CHAN_A_HIT,
    input  wire logic        O_CHAN_B_HIT
);
    logic [31:0] ctrl;
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    // Shadow of the control word, so masks and enables are known here
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) ctrl <= CTRL_RESET;
        else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == OFS_CTRL) ctrl <= I_PWDATA & CTRL_WRITE_MASK;
    end
    // Read setup followed by its access phase
    sequence rd_setup(logic [7:0] a); I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == a; endsequence
    sequence rd_access; I_PSEL && I_PENABLE; endsequence
    a_count_upper_zero: assert property (rd_setup(OFS_COUNT) ##1 rd_access |-> O_PRDATA[31:12] == 20'h0_0000)
        else $error("count upper bits not zero");
    a_dst_ptr_zero: assert property (rd_setup(OFS_DST_TRACE) ##1 rd_access |-> O_PRDATA[30:28] == 3'h0)
        else $error("destination bits 30 to 28 not zero");
    a_mask_a_hit: assert property (ctrl[CTRL_MASK_A_BIT] && I_CHAN_A_MATCH |-> O_CHAN_A_HIT)
        else $error("masked channel A match gave no hit");
    a_mask_b_hit: assert property (ctrl[CTRL_MASK_B_BIT] && I_CHAN_B_MATCH |-> O_CHAN_B_HIT)
        else $error("masked channel B match gave no hit");
    a_a_needs_match: assert property (!I_CHAN_A_MATCH |-> !O_CHAN_A_HIT)
        else $error("channel A hit without match");
    a_b_needs_match: assert property (!I_CHAN_B_MATCH |-> !O_CHAN_B_HIT)
        else $error("channel B hit without match");
    a_break_needs_hit: assert property (O_USER_BREAK |-> O_CHAN_A_HIT || O_CHAN_B_HIT)
        else $error("break without a channel hit");
    a_plain_b_break: assert property (!ctrl[CTRL_COUNT_EN_BIT] && O_CHAN_B_HIT |-> O_USER_BREAK)
        else $error("uncounted channel B hit gave no break");
endmodule
bind break_count_branch_trace_asid break_trace_checker break_trace_checker_inst (.I_CLOCK, .I_RESET_N,
    .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .I_CHAN_A_MATCH,
    .I_CHAN_B_MATCH, .O_USER_BREAK, .O_CHAN_A_HIT, .O_CHAN_B_HIT);
`default_nettype wire

// *** tb/core_model.sv ***
// Purpose: Core side: bus-cycle match events and branch pulses
// Assumes: Events launched just after a rising edge
// Notes:   Released address lines show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module core_model (
    // Clock and break seen from the block
    input  wire logic        i_clock,
    input  wire logic        i_user_break,
    // Match events
    output logic             o_a_match,
    output logic             o_b_match,
    output logic [7:0]       o_space_id,
    // Branch events
    output logic             o_branch,
    output logic [27:0]      o_src,
    output logic [2:0]       o_buf,
    output logic [27:0]      o_dst
);
    initial {o_a_match, o_b_match, o_space_id, o_branch, o_src, o_buf, o_dst} = '0;
    // One-cycle match; the break is sampled mid-cycle once it has settled
    task automatic hit(input logic a, input logic b, input logic [7:0] id, output logic brk);
        @(posedge i_clock);
        o_a_match <= a;
        o_b_match <= b;
        o_space_id <= id;
        @(negedge i_clock);
        brk = i_user_break;
        @(posedge i_clock);
        {o_a_match, o_b_match} <= 2'h0;
        o_space_id <= ~id;
    endtask
    // One-cycle branch pulse with its fetch addresses and buffer number
    task automatic branch(input logic [27:0] s, input logic [2:0] b, input logic [27:0] d);
        @(posedge i_clock);
        o_branch <= 1'b1;
        {o_src, o_buf, o_dst} <= {s, b, d};
        @(posedge i_clock);
        o_branch <= 1'b0;
        {o_src, o_buf, o_dst} <= ~{s, b, d};
    endtask
endmodule
`default_nettype wire

// *** tb/tb_break_count_branch_trace_asid.sv ***
// Purpose: Register, break and trace scenarios over APB and the core model
// Assumes: Slave answers in one access cycle, reads pop at setup
// Notes:   Expected words built from the field layout
`timescale 1ns/10ps
`default_nettype none
module tb_break_count_branch_trace_asid;
    import ubc_trace_pkg::*;
    localparam logic [27:0] SRC0 = 28'hA00_0000;
    localparam logic [27:0] DST0 = 28'h500_0000;
    logic clock = 1'b0, rst_n = 1'b0, man_n = 1'b1, psel, penable, pwrite, pready, pslverr;
    logic a_m, b_m, br, brk_out, er, bk;
    logic [7:0] paddr, sid;
    logic [31:0] pwdata, prdata, rd;
    logic [27:0] src, dst;
    logic [2:0] bufn;
    int bad_count = 0, comparisons = 0, i;
    always #50 clock = ~clock;
    break_count_branch_trace_asid break_count_branch_trace_asid_inst (.I_CLOCK(clock),
        .I_RESET_N(rst_n), .I_MANUAL_RESET_N(man_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CHAN_A_MATCH(a_m), .I_CHAN_B_MATCH(b_m),
        .I_BUS_SPACE_ID(sid), .I_BRANCH(br), .I_SRC_FETCH_ADDR(src), .I_LAST_EXEC_BUFFER(bufn),
        .I_DST_FETCH_ADDR(dst), .O_USER_BREAK(brk_out), .O_CHAN_A_HIT(), .O_CHAN_B_HIT());
    core_model core_model_inst (.i_clock(clock), .i_user_break(brk_out), .o_a_match(a_m),
        .o_b_match(b_m), .o_space_id(sid), .o_branch(br), .o_src(src), .o_buf(bufn), .o_dst(dst));
    // One APB transfer; data and error taken at the edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the watchdog ends a wait that never sees pready
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Decode pointer from the buffer number: odd pointers sit two below
    function automatic logic [2:0] ptr(input logic [2:0] b);
        return b[0] ? b - 3'h2 : b;
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well beyond the roughly 160 cycles the sequence needs
    initial begin
        #2000000;
        bad_count++;
        stop_test;
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        apb(0, OFS_COUNT, 0); check(rd, 32'h0000_0000);
        apb(1, OFS_COUNT, 32'hFFFF_FFFF); apb(0, OFS_COUNT, 0); check(rd, 32'h0000_0FFF);
        apb(1, OFS_SPACE_A, 32'h0000_01A5); apb(1, OFS_SPACE_B, 32'h0000_013C);
        apb(0, OFS_SPACE_A, 0); check(rd, 32'h0000_00A5);
        apb(0, OFS_SPACE_B, 0); check(rd, 32'h0000_003C);
        apb(0, 8'h20, 0); check(er, 1); check(rd, 32'h0000_0000);
        // Count of two: first hit counts down, second breaks, then saturated
        apb(1, OFS_CTRL, 32'h0000_0001); apb(1, OFS_COUNT, 32'h0000_0002);
        core_model_inst.hit(0, 1, 8'h3C, bk); check(bk, 0);
        core_model_inst.hit(0, 1, 8'h3C, bk); check(bk, 1);
        apb(0, OFS_COUNT, 0); check(rd, 32'h0000_0000);
        core_model_inst.hit(0, 1, 8'h3C, bk); check(bk, 0);
        // Identifier checks, then masks
        apb(1, OFS_CTRL, 32'h0000_0000);
        core_model_inst.hit(0, 1, 8'h3D, bk); check(bk, 0);
        core_model_inst.hit(0, 1, 8'h3C, bk); check(bk, 1);
        core_model_inst.hit(1, 0, 8'h3C, bk); check(bk, 0);
        apb(1, OFS_CTRL, 32'h0030_0000);
        core_model_inst.hit(1, 0, 8'h00, bk); check(bk, 1);
        core_model_inst.hit(0, 1, 8'h00, bk); check(bk, 1);
        // Tracing off, then nine branches into eight entries
        core_model_inst.branch(SRC0, 3'h1, DST0);
        apb(0, OFS_SRC_TRACE, 0); check(rd[31], 0);
        apb(1, OFS_CTRL, 32'h0000_0800);
        for (i = 0; i < 9; i++) core_model_inst.branch(28'(SRC0 + i), 3'(i), 28'(DST0 + i));
        for (i = 1; i < 9; i++) begin
            apb(0, OFS_SRC_TRACE, 0); check(rd, {1'b1, ptr(3'(i)), 28'(SRC0 + i)});
            apb(0, OFS_DST_TRACE, 0); check(rd, {4'h8, 28'(DST0 + i)});
        end
        apb(0, OFS_SRC_TRACE, 0); check(rd[31], 0);
        apb(0, OFS_DST_TRACE, 0); check(rd[31], 0);
        // Manual reset drops the valid flag of a fresh entry
        core_model_inst.branch(SRC0, 3'h2, DST0);
        @(posedge clock);
        man_n <= 1'b0;
        @(posedge clock);
        man_n <= 1'b1;
        apb(0, OFS_SRC_TRACE, 0); check(rd[31], 0);
        stop_test;
    end
endmodule
`default_nettype wire
